// ===== logic/oss_pkg.sv
// package: register map, field positions and constants for the sync/polarity control block
package oss_pkg;
  localparam logic [11:0] OFF_CTRL      = 12'h0C0;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h0C4;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h0C8;
  localparam logic [11:0] OFF_STATUS    = 12'h0CC;
  localparam logic [11:0] OFF_RMW_SET   = 12'h0D0;
  localparam logic [11:0] OFF_RMW_CLR   = 12'h0D4;
  localparam logic [11:0] OFF_VERTICAL_START    = 12'h0D8;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam int          BIT_IV        = 7;
  localparam int          BIT_PV        = 6;
  localparam int          BIT_LV        = 5;
  localparam int          BIT_PH        = 4;
  localparam int          BIT_PC        = 3;
  localparam int          BIT_PO        = 2;
  localparam int          BIT_DH        = 1;
  localparam int          BIT_BFE       = 0;
  localparam int          IRQ_VSYNC     = 0;
  localparam int          IRQ_FIELD     = 1;
  localparam int          IRQ_W         = 2;
  localparam logic [2:0]  COLOUR_BLACK  = 3'h0;
  localparam int          VCNT_W        = 10;
endpackage

// ===== logic/oss_sync_ctrl.sv
// module: sync polarity, vsync flag, overlay output polarity and indicator control
`timescale 1ns/1ps
// Operation
// [RULE1] vsync flag sets on leading vsync edge per selected polarity
// [RULE2] flag clears automatically when the vsync interrupt is vectored
// [RULE3] software writing one or zero sets or clears the flag directly
// [RULE4] vsync polarity bit picks active high (0) or active low (1)
// [RULE5] colour forced black and overlay select inactive during active vsync
// [RULE6] edge-select bit picks leading or trailing vsync edge to clear line counter
// [RULE7] hsync polarity bit picks active high (0) or active low (1)
// [RULE8] overlay select active means show colour; polarity bit inverts it
// [RULE9] colour polarity bit inverts all three colour pins
// [RULE10] internal colour code zero is always black
// [RULE11] vertical doubling bit doubles character height only
// [RULE12] vertical start count runs in hsync periods, unaffected by doubling
// [RULE13] indicator enabled: low for foreground bits, high for background bits
// [RULE14] indicator disabled: output held high
// [RULE15] bit set/clear on other bits never changes the vsync flag
// [RULE16] held background colour not shown during active hsync
// [RULE17] control register resets to zero; sync inputs synchronised first
module oss_sync_ctrl
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        vsync_in,
  input  wire logic        hsync_in,
  input  wire logic        irq_vector_ack,
  input  wire logic        pix_valid,
  input  wire logic        pix_fg,
  input  wire logic [2:0]  pix_colour,
  input  wire logic        pix_show,
  input  wire logic        pix_shadow,
  output logic      [2:0]  colour_out,
  output logic             overlay_select_out,
  output logic             fg_bg_indicator_out,
  output logic             vertical_double,
  output logic             field_start,
  output logic             irq
);
  typedef enum logic [1:0]
  {
    OSS_IDLE   = 2'b00,
    OSS_ACCESS = 2'b01
  } oss_bus_t;

  logic [1:0]                     vs_sync_q, vs_sync_d;
  logic [1:0]                     hs_sync_q, hs_sync_d;
  logic                           vs_act_q, vs_act_d;
  logic                           hs_act_q, hs_act_d;
  logic [7:0]                     ctrl_q, ctrl_d;
  logic [oss_pkg::IRQ_W-1:0]      ists_q, ists_d;
  logic [oss_pkg::IRQ_W-1:0]      imask_q, imask_d;
  logic [oss_pkg::VCNT_W-1:0]     vcnt_q, vcnt_d;
  logic [2:0]                     col_q, col_d;
  logic                           ovl_q, ovl_d;
  logic                           fgbg_q, fgbg_d;
  logic                           dbl_q, dbl_d;
  logic                           fs_q, fs_d;
  logic                           irq_q, irq_d;
  logic [31:0]                    rd_q, rd_d;
  logic                           rdy_q, rdy_d;
  logic                           err_q, err_d;
  oss_bus_t                       st_q, st_d;

  logic vs_level;
  logic hs_level;
  logic vs_lead;
  logic vs_trail;
  logic hs_lead;
  logic field_ref;
  logic wr_en;
  logic mapped;

  // qualified levels from the second synchroniser stage
  always_comb
  begin
    vs_level = vs_sync_q[1] ^ ctrl_q[oss_pkg::BIT_PV];  // [RULE4]
    hs_level = hs_sync_q[1] ^ ctrl_q[oss_pkg::BIT_PH];  // [RULE7]
    vs_lead  = vs_level & ~vs_act_q;
    vs_trail = ~vs_level & vs_act_q;
    hs_lead  = hs_level & ~hs_act_q;
    field_ref = ctrl_q[oss_pkg::BIT_LV] ? vs_trail : vs_lead;  // [RULE6]
  end

  // synchronisers and active-level history
  always_comb
  begin
    vs_sync_d = {vs_sync_q[0], vsync_in};  // [RULE17]
    hs_sync_d = {hs_sync_q[0], hsync_in};  // [RULE17]
    vs_act_d  = vs_level;
    hs_act_d  = hs_level;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vs_sync_q <= 2'h0;
      hs_sync_q <= 2'h0;
      vs_act_q  <= 1'b0;
      hs_act_q  <= 1'b0;
    end
    else
    begin
      vs_sync_q <= vs_sync_d;
      hs_sync_q <= hs_sync_d;
      vs_act_q  <= vs_act_d;
      hs_act_q  <= hs_act_d;
    end
  end

  // apb slave, single wait-state-free access phase
  always_comb
  begin
    wr_en  = psel & penable & pwrite & (st_q == OSS_ACCESS);
    mapped = (paddr == oss_pkg::OFF_CTRL) || (paddr == oss_pkg::OFF_IRQ_STAT) ||
             (paddr == oss_pkg::OFF_IRQ_MASK) || (paddr == oss_pkg::OFF_STATUS) ||
             (paddr == oss_pkg::OFF_RMW_SET) || (paddr == oss_pkg::OFF_RMW_CLR) ||
             (paddr == oss_pkg::OFF_VERTICAL_START);
    st_d  = st_q;
    rdy_d = 1'b0;
    err_d = 1'b0;
    rd_d  = rd_q;
    case (st_q)
      OSS_IDLE:
      begin
        if (psel && !penable)
        begin
          st_d  = OSS_ACCESS;
          rdy_d = 1'b1;
          err_d = ~mapped;
          rd_d  = 32'h0000_0000;
          if (!pwrite)
          begin
            case (paddr)
              oss_pkg::OFF_CTRL:     rd_d = {24'h00_0000, ctrl_q};
              oss_pkg::OFF_IRQ_STAT: rd_d = {30'h0000_0000, ists_q};
              oss_pkg::OFF_IRQ_MASK: rd_d = {30'h0000_0000, imask_q};
              oss_pkg::OFF_STATUS:   rd_d = {29'h0000_0000, hs_act_q, vs_act_q, irq_q};
              oss_pkg::OFF_VERTICAL_START:   rd_d = {22'h00_0000, vcnt_q};
              default:               rd_d = 32'h0000_0000;
            endcase
          end
        end
      end
      OSS_ACCESS:
      begin
        st_d = OSS_IDLE;
      end
      default:
      begin
        st_d = OSS_IDLE;
      end
    endcase
  end

  // control register, flag and interrupt status
  always_comb
  begin
    ctrl_d  = ctrl_q;
    ists_d  = ists_q;
    imask_d = imask_q;
    if (wr_en && !pslverr)
    begin
      case (paddr)
        oss_pkg::OFF_CTRL:     ctrl_d = pwdata[7:0];  // [RULE3]
        // bit set/clear ports touch only the named bits
        oss_pkg::OFF_RMW_SET:  ctrl_d = ctrl_q | pwdata[7:0];  // [RULE15]
        oss_pkg::OFF_RMW_CLR:  ctrl_d = ctrl_q & ~pwdata[7:0];  // [RULE15]
        oss_pkg::OFF_IRQ_STAT: ists_d = ists_q & ~pwdata[oss_pkg::IRQ_W-1:0];
        oss_pkg::OFF_IRQ_MASK: imask_d = pwdata[oss_pkg::IRQ_W-1:0];
        default:               ctrl_d = ctrl_q;
      endcase
    end
    if (irq_vector_ack)
    begin
      ctrl_d[oss_pkg::BIT_IV] = 1'b0;  // [RULE2]
    end
    // hardware set wins over any clear in the same cycle
    if (vs_lead)
    begin
      ctrl_d[oss_pkg::BIT_IV] = 1'b1;  // [RULE1]
      ists_d[oss_pkg::IRQ_VSYNC] = 1'b1;
    end
    if (field_ref)
    begin
      ists_d[oss_pkg::IRQ_FIELD] = 1'b1;
    end
    irq_d = |((ists_d | {{(oss_pkg::IRQ_W-1){1'b0}}, ctrl_d[oss_pkg::BIT_IV]}) & imask_d);
  end

  // vertical start counter in hsync periods
  always_comb
  begin
    vcnt_d = vcnt_q;
    fs_d   = field_ref;
    if (field_ref)
    begin
      vcnt_d = '0;  // [RULE6]
    end
    else if (hs_lead && (vcnt_q != {oss_pkg::VCNT_W{1'b1}}))
    begin
      vcnt_d = vcnt_q + 1'b1;  // [RULE12]
    end
  end

  // video output path
  always_comb
  begin
    logic [2:0] c;
    logic       show;
    c    = oss_pkg::COLOUR_BLACK;
    show = 1'b0;
    if (pix_valid)
    begin
      c    = pix_shadow ? oss_pkg::COLOUR_BLACK : pix_colour;  // [RULE10]
      show = pix_fg | pix_show | pix_shadow;
    end
    if (hs_act_q && !(pix_valid && (pix_fg || pix_shadow)))
    begin
      c    = oss_pkg::COLOUR_BLACK;  // [RULE16]
    end
    if (vs_act_q)
    begin
      c    = oss_pkg::COLOUR_BLACK;  // [RULE5]
      show = 1'b0;  // [RULE5]
    end
    col_d  = ctrl_q[oss_pkg::BIT_PO] ? ~c : c;  // [RULE9]
    ovl_d  = show ^ ctrl_q[oss_pkg::BIT_PC];  // [RULE8]
    if (ctrl_q[oss_pkg::BIT_BFE] && pix_valid)
    begin
      fgbg_d = ~pix_fg;  // [RULE13]
    end
    else
    begin
      fgbg_d = 1'b1;  // [RULE14]
    end
    dbl_d  = ctrl_q[oss_pkg::BIT_DH];  // [RULE11]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q    <= OSS_IDLE;
      rd_q    <= 32'h0000_0000;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      ctrl_q  <= oss_pkg::CTRL_RESET;  // [RULE17]
      ists_q  <= '0;
      imask_q <= '0;
      irq_q   <= 1'b0;
      vcnt_q  <= '0;
      fs_q    <= 1'b0;
      col_q   <= oss_pkg::COLOUR_BLACK;
      ovl_q   <= 1'b0;
      fgbg_q  <= 1'b1;
      dbl_q   <= 1'b0;
    end
    else
    begin
      st_q    <= st_d;
      rd_q    <= rd_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      ctrl_q  <= ctrl_d;
      ists_q  <= ists_d;
      imask_q <= imask_d;
      irq_q   <= irq_d;
      vcnt_q  <= vcnt_d;
      fs_q    <= fs_d;
      col_q   <= col_d;
      ovl_q   <= ovl_d;
      fgbg_q  <= fgbg_d;
      dbl_q   <= dbl_d;
    end
  end

  assign prdata              = rd_q;
  assign pready              = rdy_q;
  assign pslverr             = err_q;
  assign colour_out          = col_q;
  assign overlay_select_out  = ovl_q;
  assign fg_bg_indicator_out = fgbg_q;
  assign vertical_double     = dbl_q;
  assign field_start         = fs_q;
  assign irq                 = irq_q;

endmodule // oss_sync_ctrl

// ===== sim/oss_checker.sv
// checker: bus and output timing assertions for the sync control block
`timescale 1ns/1ps
module oss_checker
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pix_valid,
  input wire logic        fg_bg_indicator_out,
  input wire logic        field_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ctrl_read;
    pready && !pwrite && paddr == 12'h0C0;
  endsequence
  chk_ready_time: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_cause: assert property (!(psel && !penable) |=> !pready)
    else $error("pready without setup");
  chk_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_ctrl_upper: assert property (s_ctrl_read |-> prdata[31:8] == 24'h0)
    else $error("control upper bits not zero");
  chk_fgbg_idle: assert property (!pix_valid |=> fg_bg_indicator_out)
    else $error("indicator low without pixel");
  chk_field_pulse: assert property (field_start |=> !field_start)
    else $error("field start longer than a pulse");
endmodule // oss_checker

bind oss_sync_ctrl oss_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .pix_valid, .fg_bg_indicator_out, .field_start);

// ===== sim/oss_sync_src.sv
// partner: receiver sync source driving the vertical and horizontal sync pins
`timescale 1ns/1ps
module oss_sync_src
(
  input wire logic pclk,
  input wire logic vs_act,
  input wire logic hs_act,
  input wire logic vpol,
  input wire logic hpol,
  output logic     vsync_in,
  output logic     hsync_in
);
  always_ff @(posedge pclk)
  begin
    vsync_in <= vs_act ^ vpol;
    hsync_in <= hs_act ^ hpol;
  end
endmodule // oss_sync_src

// ===== sim/testbench.sv
// testbench: register, polarity, blanking and vsync flag scenarios
`timescale 1ns/1ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        vs_act, vpol, hpol, irq_vector_ack, pix_valid, pix_fg, pix_show;
  logic        overlay_select_out, fg_bg_indicator_out, vertical_double, field_start, irq;
  logic        vsync_in, hsync_in, pix_shadow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  pix_colour, colour_out;
  logic [33:0] exq[$];
  logic [33:0] e;
  logic [7:0]  v;
  int          failures = 0;
  int          check_count = 0;
  int          seed = 32'h729ab039;
  int          i;
  oss_sync_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .vsync_in, .hsync_in, .irq_vector_ack, .pix_valid, .pix_fg,
    .pix_colour, .pix_show, .pix_shadow, .colour_out, .overlay_select_out,
    .fg_bg_indicator_out, .vertical_double, .field_start, .irq);
  oss_sync_src u_src (.pclk, .vs_act, .hs_act(1'h0), .vpol, .hpol, .vsync_in, .hsync_in);
  always #50 pclk = ~pclk;
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] x);
    int n;
    @(posedge pclk);
    exq.push_back(x);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) failures++;
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d); apb(1'h1, a, d, 34'h0); endtask
  task rd(input logic [11:0] a, input logic [31:0] x); apb(1'h0, a, 32'h0, {2'h2, x}); endtask
  always @(posedge pclk)
    if (pready === 1'h1)
    begin
      e = exq.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (e[33]) chk("prdata", e[31:0], prdata);
    end
  initial
  begin
    pclk = 1'h0; presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 12'h0;
    pwdata = 32'h0; vs_act = 1'h0; vpol = 1'h0; hpol = 1'h0; irq_vector_ack = 1'h0;
    pix_valid = 1'h0; pix_fg = 1'h1; pix_show = 1'h0; pix_colour = 3'h0; pix_shadow = 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    rd(oss_pkg::OFF_CTRL, 32'h0);
    apb(1'h0, 12'h0FC, 32'h0, {2'h3, 32'h0});
    wr(oss_pkg::OFF_IRQ_MASK, 32'h1);
    pix_valid <= 1'h1;
    for (i = 0; i < 4; i++)
    begin
      v = $random(seed);
      v[7] = 1'h0;
      vpol <= v[6]; hpol <= v[4];
      pix_colour <= $random(seed); pix_show <= $random(seed);
      wr(oss_pkg::OFF_CTRL, 32'(v));
      repeat (6) @(posedge pclk);
      wr(oss_pkg::OFF_CTRL, 32'(v));
      wr(oss_pkg::OFF_IRQ_STAT, 32'h3);
      rd(oss_pkg::OFF_CTRL, 32'(v));
      @(posedge pclk);
      chk("colour_out", 32'(pix_colour ^ {3{v[2]}}), 32'(colour_out));
      chk("overlay", {31'h0, ~v[3]}, 32'(overlay_select_out));
      chk("indicator", {31'h0, ~v[0]}, 32'(fg_bg_indicator_out));
      chk("vdouble", 32'(v[1]), 32'(vertical_double));
      chk("irq", 32'h0, 32'(irq));
      pix_shadow <= 1'h1;
      repeat (2) @(posedge pclk);
      chk("shadow colour", 32'({3{v[2]}}), 32'(colour_out));
      chk("shadow overlay", {31'h0, ~v[3]}, 32'(overlay_select_out));
      pix_shadow <= 1'h0;
      vs_act <= 1'h1;
      repeat (6) @(posedge pclk);
      chk("colour_out", 32'({3{v[2]}}), 32'(colour_out));
      chk("overlay", 32'(v[3]), 32'(overlay_select_out));
      chk("irq", 32'h1, 32'(irq));
      rd(oss_pkg::OFF_CTRL, 32'(v | 8'h80));
      wr(oss_pkg::OFF_RMW_CLR, 32'h1);
      v[0] = 1'h0;
      rd(oss_pkg::OFF_CTRL, 32'(v | 8'h80));
      irq_vector_ack <= 1'h1;
      @(posedge pclk);
      irq_vector_ack <= 1'h0;
      rd(oss_pkg::OFF_CTRL, 32'(v));
      wr(oss_pkg::OFF_CTRL, 32'(v | 8'h80));
      rd(oss_pkg::OFF_CTRL, 32'(v | 8'h80));
      vs_act <= 1'h0;
      repeat (6) @(posedge pclk);
      wr(oss_pkg::OFF_CTRL, 32'(v));
      rd(oss_pkg::OFF_CTRL, 32'(v));
      wr(oss_pkg::OFF_IRQ_STAT, 32'h3);
      @(posedge pclk);
      chk("irq", 32'h0, 32'(irq));
      $display("test %0d done", i);
    end
    test_done;
  end
  initial
  begin
    #3000000;
    failures++;
    test_done;
  end
endmodule // testbench
